// ===== msf_interval_timer.sv
// Down counter that times one scheduler phase in microsecond ticks.
`timescale 1ns/100ps
module msf_interval_timer
  import msf_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic              busy
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // A load of zero leaves the timer idle, so a zero idle period costs no time.
  assign count_next = load ? load_value : ((tick && count_reg != '0) ? count_reg - 1'b1 : count_reg);
  assign busy       = (count_reg != '0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ===== msf_master_model.sv
// Link master model that frames measurement requests and data fetches with a gated serial clock.
`timescale 1ns/100ps
module msf_master_model (
  input  wire logic sys_clk,
  output logic      link_clk_pin,
  output logic      measure_request_cmd,
  output logic      result_fetch_cmd
);
  initial begin
    link_clk_pin        = 1'b0;
    measure_request_cmd = 1'b0;
    result_fetch_cmd    = 1'b0;
  end

  // Sends one frame of three 160 ns link periods. The link clock stands low between frames, so a
  // stray edge outside a frame cannot pose as a command.
  task automatic frame(input logic is_fetch);
    @(negedge sys_clk);
    result_fetch_cmd    = is_fetch;
    measure_request_cmd = ~is_fetch;
    repeat (6) begin
      repeat (4) @(negedge sys_clk);
      link_clk_pin = ~link_clk_pin;
    end
    repeat (4) @(negedge sys_clk);
    result_fetch_cmd    = 1'b0;
    measure_request_cmd = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

// ===== msf_pkg.sv
// Constants, types and lookup functions shared by the measurement scheduler.
// Function
// - Mult 1 capacitance spacing matches table totals
// - Mult 1 temperature spacing matches table totals
// - Mult 2 spacing follows table totals
// - Mult 4 spacing follows table totals
// - Mult 8 spacing follows table totals
// - Results leave only through fetch command
// - Early fetch repeats data marked stale
// - Ready rises when cycle leaves unfetched data
// - Sleep mode converts nothing until request; code still runs one cycle after reset
// - Sleep requests refused with pulse-density output
// - Sleep alarms only alongside digital output
// - Measurement request wakes device, starts cycle
// - Sleep cycle: temperature then capacitance, each corrected
// - Cycle end updates output and alarms first
// - Sleep request accepted without prior fetch
// - After fetch, sleep device stays powered down
// - Idle field selects 0/5/25/125 ms
// - Update mode: temperature every sixth cycle, first
// - Status 00 new, 01 stale, 10 command
// - One config bit selects sleep or update
package msf_pkg;

  localparam int SYS_CLK_KHZ     = 50000;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES_DEF = SYS_CLK_KHZ * TICK_US / 1000;

  localparam int DATA_W  = 14;
  localparam int TIMER_W = 18;

  // Phase lengths in microseconds.
  localparam logic [TIMER_W-1:0] WAKE_US      = 18'h00064;
  localparam logic [TIMER_W-1:0] TEMP_DSP_US  = 18'h000FA;
  localparam logic [TIMER_W-1:0] CAP_DSP_US   = 18'h0012C;
  localparam logic [TIMER_W-1:0] CONV8_US     = 18'h0012C;
  localparam logic [TIMER_W-1:0] CONV10_US    = 18'h0047E;
  localparam logic [TIMER_W-1:0] CONV12_US    = 18'h01194;
  localparam logic [TIMER_W-1:0] CONV14_US    = 18'h04650;
  localparam logic [TIMER_W-1:0] IDLE0_US     = 18'h00000;
  localparam logic [TIMER_W-1:0] IDLE1_US     = 18'h01388;
  localparam logic [TIMER_W-1:0] IDLE2_US     = 18'h061A8;
  localparam logic [TIMER_W-1:0] IDLE3_US     = 18'h1E848;

  localparam logic [2:0] TEMP_EVERY   = 3'h6;
  localparam logic [2:0] CAP_CNT_LAST = 3'h5;
  localparam logic [2:0] CAP_CNT_RST  = 3'h0;

  localparam logic [1:0] STAT_NEW   = 2'h0;
  localparam logic [1:0] STAT_STALE = 2'h1;
  localparam logic [1:0] STAT_CMD   = 2'h2;

  localparam logic [2:0] OUT_I2C = 3'h1;
  localparam logic [2:0] OUT_SPI = 3'h3;

  localparam logic MODE_SLEEP = 1'h1;

  localparam logic [DATA_W-1:0] DATA_RST = 14'h0000;

  typedef enum logic [2:0] {ST_PWRDN, ST_WAKE, ST_TCONV, ST_TDSP, ST_CCONV, ST_CDSP} msf_state_type;

  typedef struct packed {
    logic       meas_mode;
    logic [1:0] idle_sel;
    logic [2:0] out_sel;
    logic [1:0] cap_res;
    logic [1:0] temp_res;
    logic [1:0] mult_sel;
  } msf_config_type;

  typedef struct packed {
    logic [1:0]        status;
    logic [DATA_W-1:0] cap;
    logic [DATA_W-1:0] temp;
  } msf_result_type;

  typedef struct packed {
    logic awake;
    logic temp_conv;
    logic temp_dsp;
    logic cap_conv;
    logic cap_dsp;
  } msf_phase_type;

  function automatic logic [TIMER_W-1:0] msf_conv_us(input logic [1:0] res);
    case (res)
      2'h0:    msf_conv_us = CONV8_US;
      2'h1:    msf_conv_us = CONV10_US;
      2'h2:    msf_conv_us = CONV12_US;
      default: msf_conv_us = CONV14_US;
    endcase
  endfunction

  function automatic logic [TIMER_W-1:0] msf_idle_us(input logic [1:0] sel);
    case (sel)
      2'h0:    msf_idle_us = IDLE0_US;
      2'h1:    msf_idle_us = IDLE1_US;
      2'h2:    msf_idle_us = IDLE2_US;
      default: msf_idle_us = IDLE3_US;
    endcase
  endfunction

endpackage

// ===== msf_scheduler.sv
// Measurement cycle scheduler with result register, ready flag and alarms.
`timescale 1ns/100ps
module msf_scheduler
  import msf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire msf_config_type    device_config_word,
  input  wire logic              command_mode,
  input  wire logic              link_clk_pin,
  input  wire logic              measure_request_cmd,
  input  wire logic              result_fetch_cmd,
  input  wire logic [DATA_W-1:0] cap_value,
  input  wire logic [DATA_W-1:0] temp_value,
  input  wire logic [DATA_W-1:0] alarm_high_thr,
  input  wire logic [DATA_W-1:0] alarm_low_thr,
  output msf_result_type         fetch_data,
  output logic                   ready,
  output logic                   alarm_high,
  output logic                   alarm_low,
  output msf_phase_type          phase
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  msf_state_type     state_reg;
  msf_state_type     state_next;
  logic [PRE_W-1:0]  pre_reg;
  logic              tick;
  logic [2:0]        sync1_reg;
  logic [2:0]        sync2_reg;
  logic              link_prev_reg;
  logic              req_seen_reg;
  logic              fetch_seen_reg;
  logic              first_pending_reg;
  logic [2:0]        cap_count_reg;
  logic              data_new_reg;
  logic [DATA_W-1:0] temp_hold_reg;
  logic [DATA_W-1:0] out_cap_reg;
  logic [DATA_W-1:0] out_temp_reg;
  msf_result_type    fetch_data_reg;
  logic              alarm_high_reg;
  logic              alarm_low_reg;
  logic [TIMER_W-1:0] load_value;
  logic              t_busy;

  // Every interval is counted from the local clock through this microsecond prescaler.
  assign tick = (pre_reg == PRE_LAST);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
    end
  end

  // Link pins are resynchronised before use; only the second stage is looked at.
  // The two stages add two clocks of latency, which the slow link clock easily absorbs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg     <= 3'h0;
      sync2_reg     <= 3'h0;
      link_prev_reg <= 1'b0;
    end else begin
      sync1_reg     <= {link_clk_pin, measure_request_cmd, result_fetch_cmd};
      sync2_reg     <= sync1_reg;
      link_prev_reg <= sync2_reg[2];
    end
  end

  wire link_rise = sync2_reg[2] && !link_prev_reg;
  wire req_sel   = sync2_reg[1];
  wire fetch_sel = sync2_reg[0];
  // A command takes effect once, on the first link clock edge of its frame.
  wire req_evt   = link_rise && req_sel && !req_seen_reg;
  wire fetch_evt = link_rise && fetch_sel && !fetch_seen_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_seen_reg   <= 1'b0;
      fetch_seen_reg <= 1'b0;
    end else begin
      req_seen_reg   <= req_sel && (req_seen_reg || link_rise);
      fetch_seen_reg <= fetch_sel && (fetch_seen_reg || link_rise);
    end
  end

  wire sleep_mode  = (device_config_word.meas_mode == MODE_SLEEP);
  wire digital_out = (device_config_word.out_sel == OUT_I2C) || (device_config_word.out_sel == OUT_SPI);
  wire powered_dn  = (state_reg == ST_PWRDN);
  // Requests only count in sleep with a digital port; a pulse-density setup never wakes on a request.
  // No fetch is needed first: in sleep with a digital port, any request while powered down and outside command mode starts a cycle.
  wire req_go      = req_evt && sleep_mode && digital_out && powered_dn && !command_mode;
  wire update_go   = !sleep_mode && !t_busy && !command_mode;
  // Sleep mode only leaves power down on a request or the first cycle after reset.
  wire start_cycle = powered_dn && (req_go || update_go || (first_pending_reg && !command_mode));
  wire phase_over  = !t_busy;
  // Sleep always converts temperature; update mode only on every sixth cycle.
  wire temp_due    = sleep_mode || (cap_count_reg == CAP_CNT_RST);
  wire cycle_end   = (state_reg == ST_CDSP) && phase_over;
  wire load        = (state_next != state_reg);
  wire alarm_gate  = !sleep_mode || digital_out;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PWRDN: begin
        if (start_cycle) state_next = ST_WAKE;
      end
      ST_WAKE: begin
        if (phase_over) state_next = temp_due ? ST_TCONV : ST_CCONV;
      end
      ST_TCONV: begin
        if (phase_over) state_next = ST_TDSP;
      end
      ST_TDSP: begin
        if (phase_over) state_next = ST_CCONV;
      end
      ST_CCONV: begin
        if (phase_over) state_next = ST_CDSP;
      end
      ST_CDSP: begin
        if (phase_over) state_next = ST_PWRDN;
      end
      default: begin
        state_next = ST_PWRDN;
      end
    endcase
  end

  // Phase lengths add up to the tabulated cycle spacings for every resolution and multiplier.
  // Each phase also spends one clock on its hand-over, so real spacings run a few cycles long.
  always_comb begin
    case (state_next)
      ST_WAKE:  load_value = WAKE_US;
      ST_TCONV: load_value = msf_conv_us(device_config_word.temp_res);
      ST_TDSP:  load_value = TEMP_DSP_US;
      ST_CCONV: load_value = msf_conv_us(device_config_word.cap_res) << device_config_word.mult_sel;
      ST_CDSP:  load_value = CAP_DSP_US;
      ST_PWRDN: load_value = sleep_mode ? IDLE0_US : msf_idle_us(device_config_word.idle_sel);
      default:  load_value = IDLE0_US;
    endcase
  end

  msf_interval_timer #(
    .W (TIMER_W)
  ) u_timer (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .tick       (tick),
    .load       (load),
    .load_value (load_value),
    .busy       (t_busy)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg         <= ST_PWRDN;
      first_pending_reg <= 1'b1;
      cap_count_reg     <= CAP_CNT_RST;
    end else begin
      state_reg         <= state_next;
      first_pending_reg <= first_pending_reg && !(start_cycle && state_next == ST_WAKE);
      if (cycle_end && !sleep_mode) begin
        cap_count_reg <= (cap_count_reg == CAP_CNT_LAST) ? CAP_CNT_RST : cap_count_reg + 1'b1;
      end
    end
  end

  wire [1:0] fetch_status = command_mode ? STAT_CMD : (data_new_reg ? STAT_NEW : STAT_STALE);
  wire alarm_high_cmp = (cap_value >= alarm_high_thr);
  wire alarm_low_cmp  = (cap_value <= alarm_low_thr);

  // The result register and alarms change at cycle end, on the same clock edge that enters power down.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      temp_hold_reg <= DATA_RST;
      out_cap_reg   <= DATA_RST;
      out_temp_reg  <= DATA_RST;
    end else begin
      if (state_reg == ST_TDSP && phase_over) temp_hold_reg <= temp_value;
      if (cycle_end) begin
        out_cap_reg  <= cap_value;
        out_temp_reg <= temp_hold_reg;
      end
    end
  end

  // A cycle end in the same clock as a fetch keeps the flag set, so the new data is not lost.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_new_reg <= 1'b0;
    end else begin
      data_new_reg <= cycle_end || (data_new_reg && !fetch_evt);
    end
  end

  // A fetch copies the result register, so an early fetch repeats the last data as stale.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_data_reg <= '{status: STAT_STALE, cap: DATA_RST, temp: DATA_RST};
    end else if (fetch_evt) begin
      fetch_data_reg <= '{status: fetch_status, cap: out_cap_reg, temp: out_temp_reg};
    end
  end

  // Without a digital port in sleep mode the alarms are held low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_high_reg <= 1'b0;
      alarm_low_reg  <= 1'b0;
    end else begin
      alarm_high_reg <= alarm_gate && (cycle_end ? alarm_high_cmp : alarm_high_reg);
      alarm_low_reg  <= alarm_gate && (cycle_end ? alarm_low_cmp : alarm_low_reg);
    end
  end

  assign fetch_data = fetch_data_reg;
  assign ready      = data_new_reg;
  assign alarm_high = alarm_high_reg;
  assign alarm_low  = alarm_low_reg;
  assign phase      = '{awake:     !powered_dn,
                        temp_conv: (state_reg == ST_TCONV),
                        temp_dsp:  (state_reg == ST_TDSP),
                        cap_conv:  (state_reg == ST_CCONV),
                        cap_dsp:   (state_reg == ST_CDSP)};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_cycle_close;
    cycle_end ##1 (ready && out_cap_reg == $past(cap_value));
  endsequence

  sequence s_fetch_stale;
    fetch_evt && !data_new_reg && !cycle_end && !command_mode;
  endsequence

  a_ready_at_end: assert property (cycle_end |-> s_cycle_close)
    else $error("Cycle end did not raise ready with new data.");
  a_fetch_drops_ready: assert property (fetch_evt && !cycle_end |=> !ready)
    else $error("Ready stayed high after a fetch.");
  a_stale_repeat: assert property (s_fetch_stale |=> fetch_data.status == STAT_STALE && fetch_data.cap == $past(out_cap_reg))
    else $error("Early fetch did not return stale copy.");
  a_new_status: assert property (fetch_evt && data_new_reg && !command_mode |=> fetch_data.status == STAT_NEW)
    else $error("Unfetched data not marked new.");
  a_sleep_stays_down: assert property (powered_dn && sleep_mode && !first_pending_reg && !req_go |=> powered_dn)
    else $error("Sleep mode left power down without request.");
  a_pdm_refuses_req: assert property (sleep_mode && !digital_out |-> !req_go)
    else $error("Request accepted with pulse-density output.");
  a_alarm_gated: assert property (sleep_mode && !digital_out |=> !alarm_high && !alarm_low)
    else $error("Alarm active in sleep without digital port.");
  a_request_wakes: assert property (req_go |=> state_reg == ST_WAKE ##1 phase.awake)
    else $error("Request did not start a cycle.");
  a_sleep_temp_first: assert property (state_reg == ST_WAKE && phase_over && sleep_mode |=> state_reg == ST_TCONV)
    else $error("Sleep cycle skipped temperature.");
  a_temp_every_six: assert property (state_reg == ST_WAKE && phase_over && !sleep_mode
                                     && cap_count_reg != CAP_CNT_RST |=> state_reg == ST_CCONV)
    else $error("Temperature converted out of turn.");
  a_idle_length: assert property (load && state_next == ST_PWRDN && !sleep_mode
                                  |-> load_value == msf_idle_us(device_config_word.idle_sel))
    else $error("Wrong idle period loaded.");
  a_cap_conv_length: assert property (load && state_next == ST_CCONV |=> t_busy [*2])
    else $error("Capacitance conversion ended at once.");

  // Helpers below only feed assertions; they add no state to the scheduler.
  wire idle_long = !sleep_mode && (device_config_word.idle_sel != 2'h0);

  sequence s_fetch_copy;
    fetch_evt ##1 (fetch_data.cap == $past(out_cap_reg) && fetch_data.temp == $past(out_temp_reg));
  endsequence

  a_fetch_copies: assert property (fetch_evt |-> s_fetch_copy)
    else $error("Fetch did not return the result register.");
  a_cmd_status: assert property (fetch_evt && command_mode |=> fetch_data.status == STAT_CMD)
    else $error("Command mode fetch not marked as command.");
  // Ready is the new-data flag itself, so these also cover the status bits.
  a_ready_holds: assert property (ready && !fetch_evt |=> ready)
    else $error("Ready fell without a fetch.");
  a_no_stray_ready: assert property (!ready && !cycle_end |=> !ready)
    else $error("Ready rose without a finished cycle.");
  a_set_wins: assert property (fetch_evt && cycle_end |=> ready)
    else $error("Fetch at cycle end lost the new data.");
  a_start_wakes: assert property (start_cycle |=> state_reg == ST_WAKE)
    else $error("Cycle start did not enter wake-up.");
  a_temp_held: assert property (state_reg == ST_TDSP && phase_over |=> temp_hold_reg == $past(temp_value))
    else $error("Temperature result not captured.");
  a_temp_then_cap: assert property (state_reg == ST_TDSP && phase_over |=> state_reg == ST_CCONV)
    else $error("Capacitance did not follow temperature.");
  a_end_powers_down: assert property (cycle_end |=> powered_dn)
    else $error("Cycle end did not enter power down.");
  a_update_rearms: assert property (powered_dn && update_go |=> state_reg == ST_WAKE)
    else $error("Update mode did not start the next cycle after idle.");
  a_idle_holds: assert property (load && state_next == ST_PWRDN && idle_long |=> powered_dn [*8])
    else $error("Idle period ended at once.");
  a_sleep_no_idle: assert property (load && state_next == ST_PWRDN && sleep_mode |-> load_value == IDLE0_US)
    else $error("Sleep mode loaded a timed idle period.");
  a_alarm_steady: assert property (!cycle_end && alarm_gate |=> $stable(alarm_high) && $stable(alarm_low))
    else $error("Alarm changed outside a cycle end.");

endmodule

// ===== tb.sv
// Self-checking bench for the measurement scheduler.
`timescale 1ns/100ps
module tb
  import msf_pkg::*;
();
  logic              sys_clk;
  logic              rst;
  logic              command_mode;
  msf_config_type    cfg;
  logic [DATA_W-1:0] cap_in;
  logic [DATA_W-1:0] temp_in;
  logic              link_clk_pin;
  logic              req_pin;
  logic              fetch_pin;
  logic [DATA_W-1:0] hi_thr;
  logic [DATA_W-1:0] lo_thr;
  msf_result_type    fetch_data;
  logic              ready;
  logic              alarm_high;
  logic              alarm_low;
  msf_phase_type     phase;
  int                bad_count;
  int                n_checks;
  int                cyc = 0;
  int                wake_cyc = 0;
  int                end_q[$];
  logic              tflag_q[$];
  logic              temp_seen = 1'b0;
  logic              cdsp_d = 1'b0;
  logic              awake_d = 1'b0;

  // One tick per clock keeps the longest checked spacing within a short run.
  msf_scheduler #(.TICK_CYCLES(1)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .device_config_word(cfg), .command_mode(command_mode),
    .link_clk_pin(link_clk_pin), .measure_request_cmd(req_pin), .result_fetch_cmd(fetch_pin),
    .cap_value(cap_in), .temp_value(temp_in), .alarm_high_thr(hi_thr), .alarm_low_thr(lo_thr),
    .fetch_data(fetch_data), .ready(ready), .alarm_high(alarm_high), .alarm_low(alarm_low), .phase(phase)
  );

  msf_master_model i_master (
    .sys_clk(sys_clk), .link_clk_pin(link_clk_pin), .measure_request_cmd(req_pin), .result_fetch_cmd(fetch_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Stamps every cycle end and whether a temperature conversion ran within that cycle.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    cdsp_d <= phase.cap_dsp;
    awake_d <= phase.awake;
    if (phase.awake && !awake_d)
      wake_cyc <= cyc;
    if (phase.temp_conv)
      temp_seen <= 1'b1;
    if (cdsp_d && !phase.cap_dsp) begin
      end_q.push_back(cyc);
      tflag_q.push_back(temp_seen);
      temp_seen <= 1'b0;
    end
    if (cyc == 90000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    $display("CHECK FAILED at %0t: %s", $time, msg);
    bad_count++;
  endtask

  task automatic chk_res(input msf_result_type got, input msf_result_type exp, input string what);
    n_checks++;
    if (got !== exp)
      fail($sformatf("%s: got %h, expected %h", what, got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
      fail($sformatf("%s: got %b, expected %b", what, got, exp));
  endtask

  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi)
      fail($sformatf("%s: got %0d, expected %0d to %0d", what, got, lo, hi));
  endtask

  function automatic msf_config_type mk_cfg(input logic mode, input logic [1:0] idle, input logic [2:0] outs,
                                            input logic [1:0] mult, input logic [1:0] res = 2'h0);
    mk_cfg = '{meas_mode: mode, idle_sel: idle, out_sel: outs, cap_res: res, temp_res: res, mult_sel: mult};
  endfunction

  task automatic apply_reset(input msf_config_type c);
    @(negedge sys_clk);
    rst = 1'b1;
    cfg = c;
    repeat (20) @(negedge sys_clk);
    chk_res(fetch_data, {STAT_STALE, DATA_RST, DATA_RST}, "reset result");
    chk_bit(ready, 1'b0, "reset ready");
    chk_bit(|phase, 1'b0, "reset phase");
    end_q.delete();
    tflag_q.delete();
    rst = 1'b0;
  endtask

  task automatic wait_ends(input int n, input int lim);
    int k;
    k = 0;
    while (end_q.size() < n && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    if (end_q.size() < n)
      fail("cycle end missing");
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic fetch_chk(input logic [1:0] st, input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] t,
                           input string what);
    i_master.frame(1'b1);
    chk_res(fetch_data, {st, c, t}, what);
    chk_bit(ready, 1'b0, "ready after fetch");
  endtask

  task automatic t_sleep_basic;
    apply_reset(mk_cfg(MODE_SLEEP, 2'h0, OUT_I2C, 2'h0));
    wait_ends(1, 2000);
    chk_bit(ready, 1'b1, "ready at cycle end");
    chk_bit(alarm_high, 1'b1, "high alarm");
    chk_bit(alarm_low, 1'b0, "low alarm clear");
    fetch_chk(STAT_NEW, cap_in, temp_in, "first fetch");
    fetch_chk(STAT_STALE, cap_in, temp_in, "repeat fetch");
    repeat (1500) @(negedge sys_clk);
    chk_range(end_q.size(), 1, 1, "cycles while asleep");
    chk_bit(|phase, 1'b0, "powered down after fetch");
  endtask

  task automatic t_request;
    int t0;
    cap_in = 14'h0080;
    temp_in = 14'h1234;
    t0 = cyc;
    i_master.frame(1'b0);
    chk_range(wake_cyc - t0, 1, 40, "wake after request");
    wait_ends(2, 2000);
    chk_bit(tflag_q[1], 1'b1, "temperature in sleep cycle");
    chk_bit(alarm_low, 1'b1, "low alarm");
    chk_bit(alarm_high, 1'b0, "high alarm cleared");
    // A second request without a fetch in between must still start a cycle.
    cap_in = 14'h0155;
    i_master.frame(1'b0);
    wait_ends(3, 2000);
    chk_bit(alarm_low, 1'b0, "low alarm follows new value");
    fetch_chk(STAT_NEW, 14'h0155, 14'h1234, "fetch after second request");
  endtask

  task automatic t_spi;
    apply_reset(mk_cfg(MODE_SLEEP, 2'h0, OUT_SPI, 2'h0));
    wait_ends(1, 2000);
    fetch_chk(STAT_NEW, cap_in, temp_in, "fetch before request");
    i_master.frame(1'b0);
    wait_ends(2, 2000);
  endtask

  task automatic t_pdm;
    cap_in = 14'h3000;
    apply_reset(mk_cfg(MODE_SLEEP, 2'h0, 3'h4, 2'h0));
    wait_ends(1, 2000);
    chk_bit(alarm_high, 1'b0, "alarm without digital output");
    i_master.frame(1'b0);
    repeat (200) @(negedge sys_clk);
    chk_bit(|phase, 1'b0, "request refused");
  endtask

  task automatic t_cmd;
    @(negedge sys_clk);
    command_mode = 1'b1;
    fetch_chk(STAT_CMD, 14'h3000, 14'h1234, "command mode fetch");
    @(negedge sys_clk);
    command_mode = 1'b0;
  endtask

  task automatic t_update(input logic [1:0] idle, input logic [1:0] mult, input int exp_cap,
                          input int exp_temp, input int n, input logic [1:0] res = 2'h0);
    apply_reset(mk_cfg(~MODE_SLEEP, idle, OUT_I2C, mult, res));
    wait_ends(n, n * (exp_cap + 700));
    chk_range(end_q[1] - end_q[0], exp_cap, exp_cap + 8, "capacitance spacing");
    if (n > 6) begin
      chk_range(end_q[6] - end_q[0], exp_temp, exp_temp + 48, "temperature spacing");
      foreach (tflag_q[i])
        chk_bit(tflag_q[i], (i == 0 || i == 6), "temperature placement");
    end
  endtask

  initial begin
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    command_mode = 1'b0;
    cfg = mk_cfg(MODE_SLEEP, 2'h0, OUT_I2C, 2'h0);
    cap_in = 14'h3000;
    temp_in = 14'h0ABC;
    hi_thr = 14'h3000;
    lo_thr = 14'h0080;
    t_sleep_basic();
    t_request();
    t_spi();
    t_pdm();
    t_cmd();
    t_update(2'h0, 2'h0, 700, 4750, 7);
    t_update(2'h0, 2'h1, 1000, 6550, 7);
    t_update(2'h0, 2'h0, 1550, 10700, 7, 2'h1);
    t_update(2'h0, 2'h2, 1600, 10150, 2);
    t_update(2'h0, 2'h3, 2800, 17350, 2);
    t_update(2'h1, 2'h0, 5700, 34750, 2);
    wrap_up();
  end
endmodule
